// *** rtl/bsd_defs.svh ***
// What this block does
// - Skip next instruction if chosen I/O bit is zero; 1, 2 or 3 cycles.
// - Skip next instruction if chosen I/O bit is one; 1, 2 or 3 cycles.
// - Generic flag branch: PC gets PC+k+1 when flag s matches; 1 or 2 cycles.
// - Equal branch on zero flag one, unequal branch on zero flag zero.
// - Carry-high and unsigned-less branch on carry one; the others on carry zero.
// - Negative branch on negative flag one, positive branch on it zero.
// - Signed greater-equal branch when N xor V is zero; less-than when one.
// - Half-carry branches on half-carry flag one or zero; 1 or 2 cycles.
// - Transfer branches on transfer flag one or zero; 1 or 2 cycles.
// - Overflow branches add k+1 on overflow flag one or zero.
// - Interrupt-state branches on global interrupt flag one or zero.
// - Force I/O bit to one or zero, flags untouched, two cycles.
// - Logical left shift, zero into bit 0, updates Z C N V, one cycle.
// - Logical right shift, zero into bit 7, updates Z C N V, one cycle.
// - Rotates through carry in either direction, update Z C N V, one cycle.
// - Nibble exchange in one cycle with no flag change.
// - Register bit to transfer flag and back, one cycle each.
`ifndef BSD_DEFS_SVH
`define BSD_DEFS_SVH
`define BSD_ADDR_CMD 12'h000
`define BSD_ADDR_PC 12'h004
`define BSD_ADDR_FLAGS 12'h008
`define BSD_ADDR_STATUS 12'h00c
`define BSD_GPR_BASE 4'h1
`define BSD_IO_BASE 4'h2
`define BSD_PC_RST 16'h0000
`define BSD_FLAGS_RST 8'h00
`define BSD_BYTE_RST 8'h00
`define BSD_PC_STEP 16'h0001
`define BSD_PC_SKIP1 16'h0002
`define BSD_PC_SKIP2 16'h0003
`define BSD_CYC_ONE 2'h1
`define BSD_CYC_TWO 2'h2
`define BSD_CYC_THREE 2'h3
`define BSD_FL_C 0
`define BSD_FL_Z 1
`define BSD_FL_N 2
`define BSD_FL_V 3
`define BSD_FL_S 4
`define BSD_FL_H 5
`define BSD_FL_T 6
`define BSD_FL_I 7
`define BSD_ST_BUSY 0
`define BSD_ST_TAKEN 1
`define BSD_ST_CYC_LO 2
`endif

// *** rtl/bsd_exec.sv ***
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "bsd_defs.svh"
module bsd_exec #(
  parameter int NUM_GPR = 32,
  parameter int NUM_IO = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state
  output logic busy,
  output logic [15:0] pc
);
  import bsd_pkg::*;

  logic [15:0] pc_r;
  bsd_byte_t flags_r;
  bsd_byte_t gpr_r [NUM_GPR];
  bsd_byte_t io_r [NUM_IO];
  logic [1:0] cnt_r;
  logic taken_r;
  logic [1:0] last_cyc_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  bsd_cmd_s cmd;
  bsd_op_e op;
  bsd_byte_t rd_v;
  bsd_byte_t io_v;
  bsd_byte_t res;
  bsd_byte_t io_nv;
  bsd_byte_t fl;
  logic [15:0] pc_nxt;
  logic [15:0] k_ext;
  logic [1:0] cyc;
  logic gpr_we;
  logic io_we;
  logic branch;
  logic skip;
  logic take;
  logic shift;
  logic sc;
  logic busy_r;

  logic setup;
  logic acc;
  logic is_gpr;
  logic is_io;
  logic mapped;
  logic start;
  logic cmd_refused;
  logic [31:0] rdata;

  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_r;
  assign is_gpr = (paddr[11:8] == `BSD_GPR_BASE) && (32'(paddr[7:2]) < NUM_GPR);
  assign is_io = (paddr[11:8] == `BSD_IO_BASE) && (32'(paddr[7:2]) < NUM_IO);
  assign mapped = is_gpr | is_io | (paddr == `BSD_ADDR_CMD) | (paddr == `BSD_ADDR_PC)
    | (paddr == `BSD_ADDR_FLAGS) | (paddr == `BSD_ADDR_STATUS);
  assign cmd_refused = pwrite && (paddr == `BSD_ADDR_CMD) && busy_r;
  // Refusal is decided at setup, so the error answer and the start always agree
  assign start = acc & pwrite & (paddr == `BSD_ADDR_CMD) & ~pslverr_r;

  // Decode and execute the instruction carried by the write data
  always_comb begin
    cmd = bsd_cmd_s'(pwdata);
    op = bsd_op_e'(cmd.op);
    rd_v = gpr_r[cmd.rd];
    io_v = io_r[cmd.io];
    k_ext = {{9{cmd.k[6]}}, cmd.k};
    res = rd_v;
    io_nv = io_v;
    fl = flags_r;
    gpr_we = 1'b0;
    io_we = 1'b0;
    branch = 1'b0;
    skip = 1'b0;
    take = 1'b0;
    shift = 1'b0;
    sc = flags_r[`BSD_FL_C];
    cyc = `BSD_CYC_ONE;
    unique case (op)
      op_skip_if_io_bit_zero: begin skip = 1'b1; take = ~io_v[cmd.bitsel]; end
      op_skip_if_io_bit_one: begin skip = 1'b1; take = io_v[cmd.bitsel]; end
      op_branch_on_flag_high: begin branch = 1'b1; take = flags_r[cmd.bitsel]; end
      op_branch_on_flag_low: begin branch = 1'b1; take = ~flags_r[cmd.bitsel]; end
      op_branch_equal: begin branch = 1'b1; take = flags_r[`BSD_FL_Z]; end
      op_branch_unequal: begin branch = 1'b1; take = ~flags_r[`BSD_FL_Z]; end
      op_branch_carry_high, op_branch_unsigned_lt: begin
        branch = 1'b1;
        take = flags_r[`BSD_FL_C];
      end
      op_branch_carry_low, op_branch_unsigned_ge: begin
        branch = 1'b1;
        take = ~flags_r[`BSD_FL_C];
      end
      op_branch_negative: begin branch = 1'b1; take = flags_r[`BSD_FL_N]; end
      op_branch_positive: begin branch = 1'b1; take = ~flags_r[`BSD_FL_N]; end
      op_branch_signed_ge: begin
        branch = 1'b1;
        take = ~(flags_r[`BSD_FL_N] ^ flags_r[`BSD_FL_V]);
      end
      op_branch_signed_lt: begin
        branch = 1'b1;
        take = flags_r[`BSD_FL_N] ^ flags_r[`BSD_FL_V];
      end
      op_branch_half_carry_high: begin branch = 1'b1; take = flags_r[`BSD_FL_H]; end
      op_branch_half_carry_low: begin branch = 1'b1; take = ~flags_r[`BSD_FL_H]; end
      op_branch_transfer_high: begin branch = 1'b1; take = flags_r[`BSD_FL_T]; end
      op_branch_transfer_low: begin branch = 1'b1; take = ~flags_r[`BSD_FL_T]; end
      op_branch_overflow_high: begin branch = 1'b1; take = flags_r[`BSD_FL_V]; end
      op_branch_overflow_low: begin branch = 1'b1; take = ~flags_r[`BSD_FL_V]; end
      op_branch_irq_on: begin branch = 1'b1; take = flags_r[`BSD_FL_I]; end
      op_branch_irq_off: begin branch = 1'b1; take = ~flags_r[`BSD_FL_I]; end
      op_io_bit_force_one: begin
        io_we = 1'b1;
        io_nv[cmd.bitsel] = 1'b1;
        cyc = `BSD_CYC_TWO;
      end
      op_io_bit_force_zero: begin
        io_we = 1'b1;
        io_nv[cmd.bitsel] = 1'b0;
        cyc = `BSD_CYC_TWO;
      end
      op_shift_left_logical: begin shift = 1'b1; res = {rd_v[6:0], 1'b0}; sc = rd_v[7]; end
      op_shift_right_logical: begin
        shift = 1'b1;
        res = {1'b0, rd_v[7:1]};
        sc = rd_v[0];
      end
      op_rotate_up_via_carry: begin
        shift = 1'b1;
        res = {rd_v[6:0], flags_r[`BSD_FL_C]};
        sc = rd_v[7];
      end
      op_rotate_down_via_carry: begin
        shift = 1'b1;
        res = {flags_r[`BSD_FL_C], rd_v[7:1]};
        sc = rd_v[0];
      end
      op_shift_right_signed: begin
        shift = 1'b1;
        res = {rd_v[7], rd_v[7:1]};
        sc = rd_v[0];
      end
      op_nibble_exchange: begin gpr_we = 1'b1; res = {rd_v[3:0], rd_v[7:4]}; end
      op_flag_force_one: fl[cmd.bitsel] = 1'b1;
      op_flag_force_zero: fl[cmd.bitsel] = 1'b0;
      op_reg_bit_to_transfer: fl[`BSD_FL_T] = rd_v[cmd.bitsel];
      op_transfer_to_reg_bit: begin
        gpr_we = 1'b1;
        res[cmd.bitsel] = flags_r[`BSD_FL_T];
      end
      op_carry_force_one: fl[`BSD_FL_C] = 1'b1;
      op_carry_force_zero: fl[`BSD_FL_C] = 1'b0;
      op_negative_force_one: fl[`BSD_FL_N] = 1'b1;
      op_negative_force_zero: fl[`BSD_FL_N] = 1'b0;
      op_zero_flag_force_one: fl[`BSD_FL_Z] = 1'b1;
      op_zero_flag_force_zero: fl[`BSD_FL_Z] = 1'b0;
      op_nop: ;
      default: ;
    endcase
    if (shift) begin
      gpr_we = 1'b1;
      fl[`BSD_FL_C] = sc;
      fl[`BSD_FL_Z] = (res == `BSD_BYTE_RST);
      fl[`BSD_FL_N] = res[7];
      fl[`BSD_FL_V] = res[7] ^ sc;
    end
    pc_nxt = pc_r + `BSD_PC_STEP;
    if (branch && take) begin
      pc_nxt = pc_r + k_ext + `BSD_PC_STEP;
      cyc = `BSD_CYC_TWO;
    end
    if (skip && take) begin
      pc_nxt = pc_r + (cmd.next_two_word ? `BSD_PC_SKIP2 : `BSD_PC_SKIP1);
      cyc = cmd.next_two_word ? `BSD_CYC_THREE : `BSD_CYC_TWO;
    end
  end

  // Program counter and flags: instruction at start, software writes otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= `BSD_PC_RST;
      flags_r <= `BSD_FLAGS_RST;
    end else if (start) begin
      pc_r <= pc_nxt;
      flags_r <= fl;
    end else if (acc && pwrite && paddr == `BSD_ADDR_PC) begin
      pc_r <= pwdata[15:0];
    end else if (acc && pwrite && paddr == `BSD_ADDR_FLAGS) begin
      flags_r <= pwdata[7:0];
    end
  end

  // Register file and I/O space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_GPR; i++) gpr_r[i] <= `BSD_BYTE_RST;
      for (int i = 0; i < NUM_IO; i++) io_r[i] <= `BSD_BYTE_RST;
    end else if (start) begin
      if (gpr_we) gpr_r[cmd.rd] <= res;
      if (io_we) io_r[cmd.io] <= io_nv;
    end else if (acc && pwrite && is_gpr) begin
      gpr_r[paddr[6:2]] <= pwdata[7:0];
    end else if (acc && pwrite && is_io) begin
      io_r[paddr[7:2]] <= pwdata[7:0];
    end
  end

  // Cycle counter: busy for every cycle after the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      busy_r <= 1'b0;
      taken_r <= 1'b0;
      last_cyc_r <= 2'h0;
    end else if (start) begin
      cnt_r <= cyc - `BSD_CYC_ONE;
      busy_r <= (cyc != `BSD_CYC_ONE);
      taken_r <= take & (branch | skip);
      last_cyc_r <= cyc;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 2'h1;
      busy_r <= (cnt_r != 2'h1);
    end
  end

  always_comb begin
    rdata = 32'h0;
    if (is_gpr) rdata[7:0] = gpr_r[paddr[6:2]];
    else if (is_io) rdata[7:0] = io_r[paddr[7:2]];
    else if (paddr == `BSD_ADDR_PC) rdata[15:0] = pc_r;
    else if (paddr == `BSD_ADDR_FLAGS) rdata[7:0] = flags_r;
    else if (paddr == `BSD_ADDR_STATUS) begin
      rdata[`BSD_ST_BUSY] = busy_r;
      rdata[`BSD_ST_TAKEN] = taken_r;
      rdata[`BSD_ST_CYC_LO +: 2] = last_cyc_r;
    end
  end

  // APB answer: one wait-free access phase, error on unmapped or busy command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= ~mapped | cmd_refused;
        prdata_r <= pwrite ? 32'h0 : rdata;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;
  assign pc = pc_r;

  // Helper state for checks
  bsd_byte_t rd_q;
  logic bit_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= `BSD_BYTE_RST;
      bit_q <= 1'b0;
    end else begin
      rd_q <= rd_v;
      bit_q <= rd_v[cmd.bitsel];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait2;
    busy_r [*2] ##1 !busy_r;
  endsequence
  sequence s_wait1;
    busy_r ##1 !busy_r;
  endsequence

  property p_skip_zero;
    start && op == op_skip_if_io_bit_zero && !io_v[cmd.bitsel] && cmd.next_two_word
      |=> (pc_r == $past(pc_r) + `BSD_PC_SKIP2) ##0 s_wait2;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip on zero bit wrong");
  property p_skip_one;
    start && op == op_skip_if_io_bit_one && !io_v[cmd.bitsel]
      |=> pc_r == $past(pc_r) + `BSD_PC_STEP && !busy_r;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip taken on zero bit");
  property p_flag_branch;
    start && op == op_branch_on_flag_high && flags_r[cmd.bitsel]
      |=> pc_r == $past(pc_r) + $past(k_ext) + `BSD_PC_STEP ##0 s_wait1;
  endproperty
  a_flag_branch: assert property (p_flag_branch) else $error("flag branch wrong");
  property p_signed_ge;
    start && op == op_branch_signed_ge && (flags_r[`BSD_FL_N] ^ flags_r[`BSD_FL_V])
      |=> pc_r == $past(pc_r) + `BSD_PC_STEP && !busy_r;
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed branch taken wrongly");
  property p_io_force;
    start && op == op_io_bit_force_one
      |=> io_r[$past(cmd.io)][$past(cmd.bitsel)] && flags_r == $past(flags_r) ##0 s_wait1;
  endproperty
  a_io_force: assert property (p_io_force) else $error("io bit set wrong");
  property p_shl;
    start && op == op_shift_left_logical
      |=> flags_r[`BSD_FL_C] == rd_q[7] && flags_r[`BSD_FL_Z] == (rd_q[6:0] == 7'h0) && !busy_r;
  endproperty
  a_shl: assert property (p_shl) else $error("left shift flags wrong");
  property p_swap;
    start && op == op_nibble_exchange
      |=> flags_r == $past(flags_r) && gpr_r[$past(cmd.rd)] == {rd_q[3:0], rd_q[7:4]};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");
  property p_bit_store;
    start && op == op_reg_bit_to_transfer |=> flags_r[`BSD_FL_T] == bit_q && !busy_r;
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("transfer flag wrong");
endmodule // bsd_exec

// *** rtl/bsd_pkg.sv ***
package bsd_pkg;
  typedef enum logic [5:0] {
    op_nop, op_skip_if_io_bit_zero, op_skip_if_io_bit_one,
    op_branch_on_flag_high, op_branch_on_flag_low, op_branch_equal, op_branch_unequal,
    op_branch_carry_high, op_branch_carry_low, op_branch_unsigned_ge, op_branch_unsigned_lt,
    op_branch_negative, op_branch_positive, op_branch_signed_ge, op_branch_signed_lt,
    op_branch_half_carry_high, op_branch_half_carry_low, op_branch_transfer_high,
    op_branch_transfer_low, op_branch_overflow_high, op_branch_overflow_low,
    op_branch_irq_on, op_branch_irq_off, op_io_bit_force_one, op_io_bit_force_zero,
    op_shift_left_logical, op_shift_right_logical, op_rotate_up_via_carry,
    op_rotate_down_via_carry, op_shift_right_signed, op_nibble_exchange,
    op_flag_force_one, op_flag_force_zero, op_reg_bit_to_transfer, op_transfer_to_reg_bit,
    op_carry_force_one, op_carry_force_zero, op_negative_force_one, op_negative_force_zero,
    op_zero_flag_force_one, op_zero_flag_force_zero
  } bsd_op_e;

  // Instruction word written to the command register
  typedef struct packed {
    logic [3:0] pad;
    logic next_two_word;
    logic [6:0] k;
    logic [2:0] bitsel;
    logic [5:0] io;
    logic [4:0] rd;
    logic [5:0] op;
  } bsd_cmd_s;

  typedef logic [7:0] bsd_byte_t;
endpackage

// *** tb/tb_branch_skip_bit_shift_decode.sv ***
`timescale 1ns/1ps
`include "bsd_defs.svh"
module tb_branch_skip_bit_shift_decode;
  import bsd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy;
  logic [15:0] pc;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] rd_v;
  logic err;
  logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h55, 8'haa};

  always #12.5 pclk = ~pclk;

  bsd_exec dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .pc(pc));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) chk(32'h0, 32'h1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, rd_v, err);
    chk(32'(err), 32'h0, "write error");
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0, rd_v, err);
    chk(rd_v, exp, what);
  endtask

  function automatic logic [11:0] ga(input int x);
    return {`BSD_GPR_BASE, 6'(x), 2'b00};
  endfunction

  function automatic logic [11:0] ia(input int x);
    return {`BSD_IO_BASE, 6'(x), 2'b00};
  endfunction

  function automatic logic [31:0] mk(input int op, input int x, input int b,
      input logic [6:0] k, input logic two);
    bsd_cmd_s c;
    c = '{pad: 4'h0, next_two_word: two, k: k, bitsel: 3'(b), io: 6'(x), rd: 5'(x), op: 6'(op)};
    return 32'(c);
  endfunction

  // Taken when the selected flag (or N xor V) has the polarity the opcode names
  function automatic logic br_exp(input int op, input logic [7:0] f, input int s);
    logic b;
    logic h;
    case (op)
      3, 4: b = f[s];
      5, 6: b = f[1];
      7, 8, 9, 10: b = f[0];
      11, 12: b = f[2];
      13, 14: b = f[2] ^ f[3];
      15, 16: b = f[5];
      17, 18: b = f[6];
      19, 20: b = f[3];
      default: b = f[7];
    endcase
    h = (op % 2) == 1;
    if (op == 9 || op == 10 || op == 13 || op == 14) h = !h;
    return h ? b : !b;
  endfunction

  // Start from PC 0x100, issue, count busy cycles, check pc and status count
  task automatic run(input int op, input int x, input int b, input logic [6:0] k,
      input logic two, input logic [15:0] epc, input int ecyc);
    int n;
    wr(`BSD_ADDR_PC, 32'h100);
    wr(`BSD_ADDR_CMD, mk(op, x, b, k, two));
    n = 0;
    @(posedge pclk);
    while (busy === 1'b1 && n < 8) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n + 1), 32'(ecyc), "cycle count");
    chk({16'h0, pc}, {16'h0, epc}, "pc");
    apb(`BSD_ADDR_STATUS, 1'b0, 32'h0, rd_v, err);
    chk(32'(rd_v[3:2]), 32'(ecyc), "status count");
  endtask

  initial begin
    logic [7:0] f, v, r, ef;
    logic [6:0] kk;
    logic [15:0] epc;
    logic t, c;
    logic [31:0] st;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({16'h0, pc}, 32'h0, "pc after reset");
    rdc(`BSD_ADDR_PC, 32'h0, "pc reset");
    rdc(`BSD_ADDR_FLAGS, 32'h0, "flags reset");
    rdc(`BSD_ADDR_STATUS, 32'h0, "status reset");
    rdc(`BSD_ADDR_CMD, 32'h0, "cmd reads zero");
    rdc(ga(31), 32'h0, "gpr reset");
    rdc(ia(63), 32'h0, "io reset");
    apb(12'h010, 1'b1, 32'h1, rd_v, err);
    chk(32'(err), 32'h1, "unmapped write");
    apb(12'h010, 1'b0, 32'h0, rd_v, err);
    chk({31'h0, err} | rd_v, 32'h1, "unmapped read");
    for (int op = 3; op <= 22; op++) begin
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < ((op < 5) ? 8 : 1); s++) begin
          f = pats[p];
          kk = p[0] ? 7'h7d : 7'h05;
          t = br_exp(op, f, s);
          wr(`BSD_ADDR_FLAGS, 32'(f));
          epc = t ? 16'h101 + {{9{kk[6]}}, kk} : 16'h101;
          run(op, 0, s, kk, 1'b0, epc, t ? 2 : 1);
          chk(32'(rd_v[1]), 32'(t), "taken");
          rdc(`BSD_ADDR_FLAGS, 32'(f), "branch flags");
        end
      end
    end
    wr(ia(5), 32'ha5);
    for (int b = 0; b < 8; b++) begin
      for (int op = 1; op <= 2; op++) begin
        r = 8'ha5 >> b;
        t = (op == 2) ? r[0] : !r[0];
        epc = t ? (b[0] ? 16'h103 : 16'h102) : 16'h101;
        run(op, 5, b, 7'h0, b[0], epc, t ? (b[0] ? 3 : 2) : 1);
        chk(32'(rd_v[1]), 32'(t), "skip taken");
      end
    end
    wr(`BSD_ADDR_FLAGS, 32'h5a);
    wr(ia(9), 32'h3c);
    run(int'(op_io_bit_force_one), 9, 0, 7'h0, 1'b0, 16'h101, 2);
    rdc(ia(9), 32'h3d, "io bit set");
    run(int'(op_io_bit_force_zero), 9, 2, 7'h0, 1'b0, 16'h101, 2);
    rdc(ia(9), 32'h39, "io bit clear");
    rdc(`BSD_ADDR_FLAGS, 32'h5a, "io flags kept");
    for (int op = 25; op <= 29; op++) begin
      for (int p = 0; p < 4; p++) begin
        v = pats[p] ^ 8'h81;
        f = pats[p];
        wr(ga(3), 32'(v));
        wr(`BSD_ADDR_FLAGS, 32'(f));
        run(op, 3, 0, 7'h0, 1'b0, 16'h101, 1);
        case (op)
          25: {c, r} = {v, 1'b0};
          26: {r, c} = {1'b0, v};
          27: {c, r} = {v, f[0]};
          28: {r, c} = {f[0], v};
          default: {r, c} = {v[7], v};
        endcase
        ef = {f[7:4], r[7] ^ c, r[7], r == 8'h00, c};
        rdc(ga(3), 32'(r), "shift result");
        rdc(`BSD_ADDR_FLAGS, 32'(ef), "shift flags");
      end
    end
    wr(ga(3), 32'h81);
    wr(`BSD_ADDR_FLAGS, 32'h55);
    run(int'(op_nibble_exchange), 3, 0, 7'h0, 1'b0, 16'h101, 1);
    rdc(ga(3), 32'h18, "nibbles");
    rdc(`BSD_ADDR_FLAGS, 32'h55, "nibble flags");
    for (int s = 0; s < 8; s++) begin
      wr(`BSD_ADDR_FLAGS, 32'h00);
      run(int'(op_flag_force_one), 0, s, 7'h0, 1'b0, 16'h101, 1);
      rdc(`BSD_ADDR_FLAGS, 32'h1 << s, "flag set");
      wr(`BSD_ADDR_FLAGS, 32'hff);
      run(int'(op_flag_force_zero), 0, s, 7'h0, 1'b0, 16'h101, 1);
      rdc(`BSD_ADDR_FLAGS, 32'hff ^ (32'h1 << s), "flag clear");
    end
    for (int i = 0; i < 6; i++) begin
      f = i[0] ? 8'hff : 8'h00;
      ef = f ^ (8'h1 << ((i / 2 == 1) ? 2 : (i / 2 == 2) ? 1 : 0));
      wr(`BSD_ADDR_FLAGS, 32'(f));
      run(int'(op_carry_force_one) + i, 0, 0, 7'h0, 1'b0, 16'h101, 1);
      rdc(`BSD_ADDR_FLAGS, 32'(ef), "named flag");
    end
    wr(ga(4), 32'h10);
    wr(`BSD_ADDR_FLAGS, 32'h00);
    run(int'(op_reg_bit_to_transfer), 4, 4, 7'h0, 1'b0, 16'h101, 1);
    rdc(`BSD_ADDR_FLAGS, 32'h40, "bit to transfer");
    run(int'(op_transfer_to_reg_bit), 4, 0, 7'h0, 1'b0, 16'h101, 1);
    rdc(ga(4), 32'h11, "transfer to bit");
    run(int'(op_reg_bit_to_transfer), 4, 3, 7'h0, 1'b0, 16'h101, 1);
    rdc(`BSD_ADDR_FLAGS, 32'h00, "bit zero to transfer");
    run(int'(op_transfer_to_reg_bit), 4, 4, 7'h0, 1'b0, 16'h101, 1);
    rdc(ga(4), 32'h01, "transfer zero to bit");
    run(63, 0, 0, 7'h0, 1'b0, 16'h101, 1);
    run(int'(op_nop), 0, 0, 7'h0, 1'b0, 16'h101, 1);
    // Second command during a three-cycle skip must be refused
    wr(`BSD_ADDR_PC, 32'h100);
    wr(`BSD_ADDR_CMD, mk(int'(op_skip_if_io_bit_one), 5, 0, 7'h0, 1'b1));
    apb(`BSD_ADDR_CMD, 1'b1, mk(int'(op_io_bit_force_one), 9, 7, 7'h0, 1'b0), st, err);
    chk(32'(err), 32'h1, "busy refusal");
    repeat (4) @(posedge pclk);
    rdc(ia(9), 32'h39, "refused cmd ignored");
    chk({16'h0, pc}, 32'h103, "skip pc kept");
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
endmodule // tb_branch_skip_bit_shift_decode
